// ==== core/spi_regport.sv ====
// Serial register access port: opcode decode, burst read and write, calibration result capture.
`timescale 1ns/1ps
`include "spi_regport_cfg.svh"

module spi_regport (
   input wire logic CLK_SYS, // System clock, 100 MHz.
   input wire logic RST, // Synchronous reset, active high.
   input wire logic SCK, // Serial clock pin from the host.
   input wire logic CE_N, // Chip enable pin, active low.
   input wire logic DIN, // Serial data in pin.
   output logic DOUT, // Serial data out.
   output logic DOUT_OE, // High while the port drives serial data out.
   input wire logic CAL_DONE, // One-cycle pulse from the calibration engine.
   input wire logic [15:0] CAL_COUNT, // Measured 32 kHz period count, valid with CAL_DONE.
   input wire logic INT_ENABLE, // Level that enables the calibration interrupt.
   output logic INT_N, // Interrupt pin, active low.
   output logic CAL_START, // One-cycle pulse that starts calibration.
   output logic CMD_STROBE, // One-cycle pulse for any other execution opcode.
   output logic [7:0] CMD_CODE // Opcode that goes with CMD_STROBE.
);

   // Writable locations: boost configuration block and the clock through control block.
   function automatic logic writable(input logic [6:0] a);
      writable = (a >= `ADDR_CFG_FIRST && a <= `ADDR_CFG_LAST) ||
         (a >= `ADDR_MAIN_FIRST && a <= `ADDR_WR_LAST);
   endfunction

   // Readable locations add the result and status area above the writable block.
   function automatic logic readable(input logic [6:0] a);
      readable = (a >= `ADDR_CFG_FIRST && a <= `ADDR_CFG_LAST) ||
         (a >= `ADDR_MAIN_FIRST && a <= `ADDR_RD_LAST);
   endfunction

   // Next address in a burst; the gap between the two sections is skipped.
   function automatic logic [6:0] next_addr(input logic [6:0] a, input logic [6:0] last);
      if (a == `ADDR_CFG_LAST) begin
         next_addr = `ADDR_MAIN_FIRST;
      end else if (a == last) begin
         next_addr = `ADDR_CFG_FIRST;
      end else begin
         next_addr = a + 7'h01;
      end
   endfunction

   // Implemented bits of each writable location.
   function automatic logic [15:0] wmask(input logic [6:0] a);
      case (a)
         7'h14: wmask = `MASK_BOOST_A;
         7'h31, 7'h35: wmask = `MASK_HOURS;
         7'h36, 7'h37: wmask = `MASK_NONE;
         7'h38: wmask = `MASK_LAUNCH;
         7'h3A, 7'h3B, 7'h3C: wmask = `MASK_HIT_PICK;
         7'h3F: wmask = `MASK_SCHED_A;
         7'h40: wmask = `MASK_SCHED_B;
         7'h42: wmask = `MASK_CALCTL;
         7'h43: wmask = `MASK_RTCCTL;
         default: wmask = writable(a) ? `MASK_FULL : `MASK_NONE;
      endcase
   endfunction

   logic sck_s1, sck_s2, sck_s3;
   logic ce_s1, ce_s2, ce_s3;
   logic din_s1, din_s2;
   spi_regport_pkg::state_type state;
   logic [3:0] bit_cnt;
   logic [7:0] opc_sh;
   logic [15:0] wr_sh;
   logic [15:0] dout_sh;
   logic [6:0] addr;
   logic [15:0] regs [0:127];
   logic [15:0] cal_result;
   logic [15:0] int_status;

   // Pins come from the host's domain; two flops first, the third only feeds edge detection.
   always_ff @(posedge CLK_SYS) begin
      sck_s1 <= SCK;
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;
      ce_s1 <= CE_N;
      ce_s2 <= ce_s1;
      ce_s3 <= ce_s2;
      din_s1 <= DIN;
      din_s2 <= din_s1;
   end

   // Edge and decode terms.
   wire sck_rise = sck_s2 && !sck_s3;
   wire ce_fall = !ce_s2 && ce_s3;
   wire ce_rise = ce_s2 && !ce_s3;
   wire [7:0] opc_full = {opc_sh[6:0], din_s2};
   wire opc_done = (state == spi_regport_pkg::ST_OPCODE) && sck_rise && bit_cnt == `OPC_BITS;
   wire opc_is_read = opc_full[`OPC_READ_BIT] && readable(opc_full[6:0]);
   wire opc_is_write = !opc_full[`OPC_READ_BIT] && writable(opc_full[6:0]);
   wire rd_word_done = (state == spi_regport_pkg::ST_READ) && sck_rise && bit_cnt == `WORD_BITS;
   wire wr_word_done = (state == spi_regport_pkg::ST_WRITE) && sck_rise && bit_cnt == `WORD_BITS;
   wire [15:0] wr_word = {wr_sh[14:0], din_s2};
   wire wr_en = wr_word_done && writable(addr);
   wire load_word = (opc_done && opc_is_read) || rd_word_done;
   wire [6:0] load_addr = opc_done ? opc_full[6:0] : next_addr(addr, `ADDR_RD_LAST);
   wire exec_go = ce_rise && state == spi_regport_pkg::ST_EXEC;
   wire exec_reset = exec_go && opc_sh == `OPC_RESET;
   wire exec_init = exec_go && opc_sh == `OPC_INIT;
   wire clear_all = RST || exec_reset;

   // Read data selection; unimplemented result slots read zero.
   wire [15:0] load_data = (load_addr == `REG_CAL_RESULT) ? cal_result :
      (load_addr == `REG_INT_STATUS) ? int_status :
      regs[load_addr] & wmask(load_addr);
   wire int_clear = load_word && load_addr == `REG_INT_STATUS;

   // Transfer sequencer; a released enable always returns to idle or executes.
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         state <= spi_regport_pkg::ST_IDLE;
         bit_cnt <= 4'h0;
         opc_sh <= 8'h00;
         addr <= 7'h00;
      end else if (ce_fall) begin
         state <= spi_regport_pkg::ST_OPCODE;
         bit_cnt <= 4'h0;
      end else if (ce_s2) begin
         state <= spi_regport_pkg::ST_IDLE;
      end else begin
         unique case (state)
            spi_regport_pkg::ST_IDLE: begin
               bit_cnt <= 4'h0;
            end
            spi_regport_pkg::ST_OPCODE: begin
               if (sck_rise) begin
                  opc_sh <= opc_full;
                  bit_cnt <= bit_cnt + 4'h1;
                  if (bit_cnt == `OPC_BITS) begin
                     bit_cnt <= 4'h0;
                     addr <= opc_full[6:0];
                     if (opc_is_read) begin
                        state <= spi_regport_pkg::ST_READ;
                     end else if (opc_is_write) begin
                        state <= spi_regport_pkg::ST_WRITE;
                     end else begin
                        state <= spi_regport_pkg::ST_EXEC;
                     end
                  end
               end
            end
            spi_regport_pkg::ST_READ: begin
               if (sck_rise) begin
                  bit_cnt <= bit_cnt + 4'h1;
               end
               if (rd_word_done) begin
                  addr <= load_addr;
               end
            end
            spi_regport_pkg::ST_WRITE: begin
               if (sck_rise) begin
                  bit_cnt <= bit_cnt + 4'h1;
               end
               if (wr_word_done) begin
                  addr <= next_addr(addr, `ADDR_WR_LAST);
               end
            end
            spi_regport_pkg::ST_EXEC: begin
               bit_cnt <= 4'h0;
            end
            default: begin
               state <= spi_regport_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Write shifter and read shifter; both work on whole words only.
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         wr_sh <= `ZERO_WORD;
         dout_sh <= `ZERO_WORD;
      end else begin
         if (state == spi_regport_pkg::ST_WRITE && sck_rise) begin
            wr_sh <= wr_word;
         end
         if (load_word) begin
            dout_sh <= load_data;
         end else if (state == spi_regport_pkg::ST_READ && sck_rise) begin
            dout_sh <= {dout_sh[14:0], 1'b0};
         end
      end
   end

   // Register array; reset and the reset opcode restore defaults, initialise covers 14h-17h only.
   always_ff @(posedge CLK_SYS) begin
      for (int i = 0; i < 128; i++) begin
         if (clear_all || (exec_init && i >= 20 && i <= 23)) begin
            regs[i] <= (i >= 20 && i <= 23) ? `CFG_POR : `ZERO_WORD;
         end else if (wr_en && addr == i[6:0]) begin
            regs[i] <= wr_word & wmask(addr);
         end
      end
   end

   // Calibration result and status; a new event wins over the clear that a read makes.
   always_ff @(posedge CLK_SYS) begin
      if (clear_all) begin
         cal_result <= `ZERO_WORD;
         int_status <= `ZERO_WORD;
      end else begin
         if (CAL_DONE) begin
            cal_result <= CAL_COUNT;
         end
         if (CAL_DONE) begin
            int_status[`INT_CAL_BIT] <= 1'b1;
         end else if (int_clear) begin
            int_status[`INT_CAL_BIT] <= 1'b0;
         end
      end
   end

   // Command strobes fire once the enable is released after a non-register opcode.
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         CAL_START <= 1'b0;
         CMD_STROBE <= 1'b0;
         CMD_CODE <= 8'h00;
      end else begin
         CAL_START <= exec_go && opc_sh == `OPC_CAL;
         CMD_STROBE <= exec_go && opc_sh != `OPC_CAL;
         if (exec_go) begin
            CMD_CODE <= opc_sh;
         end
      end
   end

   // The pin is driven only in the read phase, so the opcode phase never collides with the host.
   assign DOUT = dout_sh[15];
   assign DOUT_OE = (state == spi_regport_pkg::ST_READ);
   assign INT_N = !(int_status[`INT_CAL_BIT] && INT_ENABLE);

   // Checks of the port's promises; one also guards the strobe pulse widths that a bench could miss.
   property p_cal_result;
      @(posedge CLK_SYS) disable iff (RST)
         CAL_DONE && !exec_reset |=> cal_result == $past(CAL_COUNT);
   endproperty
   a_cal_result: assert property (p_cal_result) else $error("count not stored");

   property p_cal_int;
      @(posedge CLK_SYS) disable iff (RST)
         CAL_DONE && INT_ENABLE && !exec_reset |=> !INT_N && int_status[`INT_CAL_BIT];
   endproperty
   a_cal_int: assert property (p_cal_int) else $error("calibration interrupt missing");

   property p_read_only;
      @(posedge CLK_SYS) disable iff (RST)
         wr_en |-> addr < `REG_CAL_RESULT;
   endproperty
   a_read_only: assert property (p_read_only) else $error("write to read-only slot");

   property p_oe_after_opcode;
      @(posedge CLK_SYS) disable iff (RST)
         $rose(DOUT_OE) |-> $past(opc_done) && $past(bit_cnt) == `OPC_BITS;
   endproperty
   a_oe_after_opcode: assert property (p_oe_after_opcode) else $error("early drive");

   property p_msb_first;
      @(posedge CLK_SYS) disable iff (RST)
         load_word && !ce_fall && !ce_s2 |=> DOUT == $past(load_data[15]);
   endproperty
   a_msb_first: assert property (p_msb_first) else $error("word not started at MSB");

   property p_read_inc;
      @(posedge CLK_SYS) disable iff (RST)
         rd_word_done && !ce_s2 |=> addr == next_addr($past(addr), `ADDR_RD_LAST);
   endproperty
   a_read_inc: assert property (p_read_inc) else $error("read address not advanced");

   property p_write_store;
      @(posedge CLK_SYS) disable iff (RST)
         wr_en && !ce_s2 |=> regs[$past(addr)] == ($past(wr_word) & wmask($past(addr)));
   endproperty
   a_write_store: assert property (p_write_store) else $error("write word not stored");

   property p_write_wrap;
      @(posedge CLK_SYS) disable iff (RST)
         wr_word_done && !ce_s2 && addr == `ADDR_WR_LAST |=> addr == `ADDR_CFG_FIRST;
   endproperty
   a_write_wrap: assert property (p_write_wrap) else $error("burst write did not wrap");

   property p_reset_values;
      @(posedge CLK_SYS)
         RST |=> regs[20] == `CFG_POR && regs[48] == `ZERO_WORD && int_status == `ZERO_WORD
            && cal_result == `ZERO_WORD;
   endproperty
   a_reset_values: assert property (p_reset_values) else $error("reset values");

   property p_exec_on_release;
      @(posedge CLK_SYS) disable iff (RST)
         CAL_START |-> $past(ce_rise) && $past(state) == spi_regport_pkg::ST_EXEC;
   endproperty
   a_exec_on_release: assert property (p_exec_on_release) else $error("command early");

   property p_strobe_rel;
      @(posedge CLK_SYS) disable iff (RST)
         CMD_STROBE |-> $past(ce_rise) && $past(state) == spi_regport_pkg::ST_EXEC;
   endproperty
   a_strobe_rel: assert property (p_strobe_rel) else $error("strobe early");

   property p_strobe_pulse;
      @(posedge CLK_SYS) disable iff (RST)
         CAL_START || CMD_STROBE |=> !CAL_START && !CMD_STROBE;
   endproperty
   a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe too long");

   property p_status_clear;
      @(posedge CLK_SYS) disable iff (RST)
         int_clear && !CAL_DONE |=> !int_status[`INT_CAL_BIT];
   endproperty
   a_status_clear: assert property (p_status_clear) else $error("status not cleared");

   property p_init_cfg;
      @(posedge CLK_SYS) disable iff (RST)
         exec_init |=> regs[`ADDR_CFG_FIRST] == `CFG_POR && regs[`ADDR_CFG_LAST] == `CFG_POR;
   endproperty
   a_init_cfg: assert property (p_init_cfg) else $error("initialise missed");

   property p_word_align;
      @(posedge CLK_SYS) disable iff (RST)
         opc_done && !ce_s2 |=> bit_cnt == 4'h0;
   endproperty
   a_word_align: assert property (p_word_align) else $error("word count not cleared");

   c_read_burst: cover property (@(posedge CLK_SYS) rd_word_done ##[1:400] rd_word_done);
   c_write_wrap: cover property (@(posedge CLK_SYS) wr_word_done && addr == `ADDR_WR_LAST);
   c_cal_cycle: cover property (@(posedge CLK_SYS) CAL_START ##[1:1000] CAL_DONE);

endmodule

// ==== core/spi_regport_cfg.svh ====
// Constants for the serial register access port: offsets, masks, reset values and opcodes.
`ifndef SPI_REGPORT_CFG_SVH
`define SPI_REGPORT_CFG_SVH

// Register indices; the write opcode equals the index and the read opcode adds bit 7.
`define REG_BOOST_CONV_CFG_A 7'h14
`define REG_BOOST_CONV_CFG_B 7'h15
`define REG_TIME_SUBMINUTE 7'h30
`define REG_TIME_CLOCK_MH 7'h31
`define REG_CALENDAR_WEEKDAY_MONTHDAY 7'h32
`define REG_CALENDAR_MONTH_YEAR 7'h33
`define REG_WATCHDOG_COUNTDOWN 7'h34
`define REG_ALARM_MATCH 7'h35
`define REG_CAL_RESULT 7'h44
`define REG_INT_STATUS 7'h7E

// Bounds of the map sections.
`define ADDR_CFG_FIRST 7'h14
`define ADDR_CFG_LAST 7'h17
`define ADDR_MAIN_FIRST 7'h30
`define ADDR_WR_LAST 7'h43
`define ADDR_RD_LAST 7'h7F

// Opcode layout and execution opcodes.
`define OPC_READ_BIT 7
`define OPC_RESET 8'h04
`define OPC_INIT 8'h05
`define OPC_CAL 8'h0E

// Interrupt status layout.
`define INT_CAL_BIT 0

// Reset values.
`define CFG_POR 16'h0000
`define ZERO_WORD 16'h0000

// Masks of the implemented bits; reserved bits are cleared on write and read back as zero.
`define MASK_FULL 16'hFFFF
`define MASK_NONE 16'h0000
`define MASK_BOOST_A 16'hF0FF
`define MASK_HOURS 16'hFF7F
`define MASK_LAUNCH 16'hFFF8
`define MASK_HIT_PICK 16'h3F3F
`define MASK_SCHED_A 16'hFFFE
`define MASK_SCHED_B 16'hFF9F
`define MASK_CALCTL 16'h0FFF
`define MASK_RTCCTL 16'h007F

// Serial framing.
`define OPC_BITS 4'd7
`define WORD_BITS 4'd15

`endif

// ==== core/spi_regport_pkg.sv ====
// Types shared by the serial register access port.
package spi_regport_pkg;

   // Transfer phases, Gray coded from idle to opcode and from opcode to read or write.
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_OPCODE = 3'b001,
      ST_READ = 3'b011,
      ST_WRITE = 3'b101,
      ST_EXEC = 3'b110
   } state_type;

endpackage

// ==== test/spi_host_model.sv ====
// Host-side serial master model that frames opcode, write and read transfers.
`timescale 1ns/1ps

module spi_host_model (
   input wire logic CLK_SYS, // System clock, only used to keep link edges off its edges.
   output logic SCK, // Serial clock towards the port, idle low.
   output logic CE_N, // Chip enable towards the port, active low.
   output logic DIN, // Serial data towards the port.
   input wire logic DOUT, // Serial data from the port.
   input wire logic DOUT_OE // High while the port drives DOUT.
);
   localparam realtime HALF = 62.5;

   // Idle levels; the clock stands still low between frames.
   initial begin
      SCK = 1'b0;
      CE_N = 1'b1;
      DIN = 1'b0;
   end

   // One bit: data changes while the clock is low, and DOUT is taken just before the rise.
   // An undriven DOUT has no pull, so the model then sees the inverse of the last level.
   task automatic bit_cycle(input logic d, output logic q);
      DIN = d;
      #HALF;
      q = DOUT_OE ? DOUT : ~DOUT;
      SCK = 1'b1;
      #HALF;
      SCK = 1'b0;
   endtask

   // Whole frame: the opcode goes out complete before any word, then n words MSB first.
   task automatic frame(input logic [7:0] op, input int n, input logic [15:0] wr [4],
                        output logic [15:0] rd [4]);
      logic q;
      // Start 1 ns after a system edge so that no link edge ever meets a sampling edge.
      @(posedge CLK_SYS);
      #1;
      CE_N = 1'b0;
      #HALF;
      for (int b = 7; b >= 0; b--) begin
         bit_cycle(op[b], q);
      end
      for (int i = 0; i < n; i++) begin
         for (int b = 15; b >= 0; b--) begin
            bit_cycle(wr[i][b], rd[i][b]);
         end
      end
      // DIN has no pull, so after release it shows the inverse of its last bit.
      CE_N = 1'b1;
      DIN = ~DIN;
      #(4 * HALF);
   endtask
endmodule

// ==== test/spi_register_access_port_tb.sv ====
// Self-checking bench for the serial register access port.
`timescale 1ns/1ps
`include "spi_regport_cfg.svh"

module spi_register_access_port_tb;
   typedef struct {logic [6:0] a; logic [15:0] d; logic [15:0] e;} row_type;
   logic CLK_SYS, RST, SCK, CE_N, DIN, DOUT, DOUT_OE, CAL_DONE, INT_ENABLE, INT_N;
   logic CAL_START, CMD_STROBE;
   logic [15:0] CAL_COUNT;
   logic [7:0] CMD_CODE;
   logic [15:0] w [4];
   logic [15:0] r [4];
   logic [15:0] v;
   int mismatches = 0;
   int total_checks = 0;
   int cycles = 0;
   localparam int CEIL = 40000;
   row_type rows [11];

   spi_regport DUT (.CLK_SYS(CLK_SYS), .RST(RST), .SCK(SCK), .CE_N(CE_N), .DIN(DIN),
      .DOUT(DOUT), .DOUT_OE(DOUT_OE), .CAL_DONE(CAL_DONE), .CAL_COUNT(CAL_COUNT),
      .INT_ENABLE(INT_ENABLE), .INT_N(INT_N), .CAL_START(CAL_START),
      .CMD_STROBE(CMD_STROBE), .CMD_CODE(CMD_CODE));

   spi_host_model host (.CLK_SYS(CLK_SYS), .SCK(SCK), .CE_N(CE_N), .DIN(DIN), .DOUT(DOUT),
      .DOUT_OE(DOUT_OE));

   // System clock at 100 MHz.
   initial begin
      CLK_SYS = 1'b0;
      forever #5 CLK_SYS = ~CLK_SYS;
   end

   // Cuts a hang short; the ceiling is about three times the expected run.
   always @(posedge CLK_SYS) begin
      cycles++;
      if (cycles == CEIL) begin
         mismatches++;
         $display("BAD t=%0t timeout", $time);
         end_sim;
      end
   end

   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Single-word accesses; the read opcode is the write opcode with bit 7 set.
   task automatic wr1(input logic [6:0] a, input logic [15:0] d);
      w[0] = d;
      host.frame({1'b0, a}, 1, w, r);
   endtask

   task automatic rd1(input logic [6:0] a, output logic [15:0] d);
      host.frame({1'b1, a}, 1, w, r);
      d = r[0];
   endtask

   // Sends a frame and watches for the strobe in parallel, since it lasts one cycle.
   task automatic cmd(input logic [7:0] op, input int n, input logic cal);
      logic seen;
      seen = 1'b0;
      fork
         host.frame(op, n, w, r);
         for (int k = 0; k < 600 && !seen; k++) begin
            @(posedge CLK_SYS);
            #1;
            seen = cal ? (CAL_START === 1'b1) : (CMD_STROBE === 1'b1);
         end
      join
      check({15'h0000, seen}, 16'h0001, "strobe");
      check({8'h00, CMD_CODE}, {8'h00, op}, "code");
   endtask

   initial begin
      RST = 1'b1;
      CAL_DONE = 1'b0;
      CAL_COUNT = 16'h0000;
      INT_ENABLE = 1'b1;
      rows = '{'{7'h30, 16'h1234, 16'h1234}, '{7'h31, 16'hFFFF, 16'hFF7F},
         '{7'h32, 16'hA5C3, 16'hA5C3}, '{7'h33, 16'h5A3C, 16'h5A3C},
         '{7'h34, 16'h0F0F, 16'h0F0F}, '{7'h35, 16'hFFFF, 16'hFF7F},
         '{7'h14, 16'hA0C3, 16'hA0C3}, '{7'h15, 16'hA5A9, 16'hA5A9},
         '{7'h36, 16'hFFFF, 16'h0000}, '{7'h42, 16'h0ABC, 16'h0ABC},
         '{7'h43, 16'h0055, 16'h0055}};
      repeat (10) @(posedge CLK_SYS);
      RST <= 1'b0;
      repeat (4) @(posedge CLK_SYS);
      rd1(`REG_TIME_SUBMINUTE, v);
      check(v, `ZERO_WORD, "rtc after reset");
      rd1(`REG_BOOST_CONV_CFG_A, v);
      check(v, `CFG_POR, "cfg after reset");
      $display("reset values done");
      // Write then read back each row; reserved bits must read as zero.
      foreach (rows[i]) begin
         wr1(rows[i].a, rows[i].d);
         rd1(rows[i].a, v);
         check(v, rows[i].e, "row");
      end
      $display("table rows done");
      // Output drive must not start before the eighth opcode bit is in.
      fork
         host.frame({1'b1, `REG_TIME_SUBMINUTE}, 1, w, r);
         begin
            repeat (8) @(posedge SCK);
            #1 check({15'h0000, DOUT_OE}, 16'h0000, "early drive");
            repeat (8) @(posedge CLK_SYS);
            #1 check({15'h0000, DOUT_OE}, 16'h0001, "late drive");
         end
      join
      check(r[0], 16'h1234, "msb first read");
      $display("drive order done");
      // Burst write across the top of the writable map, then a burst read.
      w = '{16'h0123, 16'h0045, 16'hA0C3, 16'h0000};
      host.frame({1'b0, 7'h42}, 3, w, r);
      w = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
      host.frame({1'b1, 7'h42}, 2, w, r);
      check(r[0], 16'h0123, "burst first");
      check(r[1], 16'h0045, "burst second");
      rd1(`REG_BOOST_CONV_CFG_A, v);
      check(v, 16'hA0C3, "burst wrap");
      $display("burst done");
      // Calibration completes; status is read before the result.
      cmd(`OPC_CAL, 0, 1'b1);
      @(posedge CLK_SYS);
      CAL_DONE <= 1'b1;
      CAL_COUNT <= 16'h7A31;
      @(posedge CLK_SYS);
      CAL_DONE <= 1'b0;
      CAL_COUNT <= 16'hFFFF;
      #1 check({15'h0000, INT_N}, 16'h0000, "irq asserted");
      @(posedge CLK_SYS);
      INT_ENABLE <= 1'b0;
      @(posedge CLK_SYS);
      #1 check({15'h0000, INT_N}, 16'h0001, "irq masked");
      @(posedge CLK_SYS);
      INT_ENABLE <= 1'b1;
      rd1(`REG_INT_STATUS, v);
      check(v, 16'h0001, "status");
      check({15'h0000, INT_N}, 16'h0001, "irq cleared");
      rd1(`REG_CAL_RESULT, v);
      check(v, 16'h7A31, "cal result");
      w[0] = 16'h5555;
      cmd({1'b0, `REG_CAL_RESULT}, 1, 1'b0);
      rd1(`REG_CAL_RESULT, v);
      check(v, 16'h7A31, "result kept");
      $display("calibration done");
      // Initialise reloads only configuration; the reset command clears the rest.
      cmd(`OPC_INIT, 0, 1'b0);
      rd1(`REG_BOOST_CONV_CFG_A, v);
      check(v, `CFG_POR, "init cfg");
      rd1(`REG_TIME_SUBMINUTE, v);
      check(v, 16'h1234, "init keeps rtc");
      cmd(`OPC_RESET, 0, 1'b0);
      rd1(`REG_TIME_SUBMINUTE, v);
      check(v, `ZERO_WORD, "cmd reset rtc");
      rd1(`REG_CAL_RESULT, v);
      check(v, `ZERO_WORD, "cmd reset result");
      $display("commands done");
      // A second hardware reset in mid-run.
      wr1(`REG_ALARM_MATCH, 16'h1111);
      wr1(7'h42, 16'h0ABC);
      wr1(`REG_BOOST_CONV_CFG_A, 16'hA0C3);
      @(posedge CLK_SYS);
      RST <= 1'b1;
      repeat (10) @(posedge CLK_SYS);
      RST <= 1'b0;
      repeat (4) @(posedge CLK_SYS);
      rd1(`REG_ALARM_MATCH, v);
      check(v, `ZERO_WORD, "alarm after reset");
      rd1(7'h42, v);
      check(v, `ZERO_WORD, "control after reset");
      rd1(`REG_BOOST_CONV_CFG_A, v);
      check(v, `CFG_POR, "cfg after second reset");
      $display("second reset done");
      end_sim;
   end
endmodule
